// >>> inc/bst_pkg.sv
`default_nettype none
package bst_pkg;
   // ------------------------------------------------------------
   // register map
   // ------------------------------------------------------------
   localparam logic [7:0] BST_IDX_SOFTSTART = 8'h05;
   localparam logic [7:0] BST_IDX_DELAY = 8'h06;
   localparam logic [7:0] BST_IDX_STATUS = 8'h0a;
   localparam int BST_ADDR_W = 12;
   localparam logic [3:0] BST_SOFTSTART_RST = 4'h4;
   localparam logic [3:0] BST_DELAY_RST = 4'h2;
   localparam int BST_FIELD_MSB = 3;
   localparam int BST_FIELD_LSB = 0;
   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int BST_CLK_HZ = 200_000_000;
   localparam int BST_BASE_US = 500;
   localparam int BST_BASE_CYC = (BST_CLK_HZ / 1_000_000) * BST_BASE_US;
   localparam logic [9:0] BST_STEP_TICKS = 10'h00a;
   localparam logic [9:0] BST_MIN_RAMP_TICKS = 10'h001;
   localparam int BST_CNT_W = 10;
   // ------------------------------------------------------------
   // sequencer states
   // ------------------------------------------------------------
   typedef enum logic [1:0]
   {
      BST_IDLE = 2'b00,
      BST_DELAY = 2'b01,
      BST_RAMP = 2'b10,
      BST_DONE = 2'b11
   } bst_state_t;
endpackage
`default_nettype wire

// >>> verilog/bst_interval_timer.sv
`default_nettype none
module bst_interval_timer
   import bst_pkg::*;
(
   // clock, reset, enable
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // control
   input wire logic load,
   input wire logic [BST_CNT_W-1:0] load_val,
   input wire logic tick,
   // status
   output logic busy,
   output logic expire
);
   logic [BST_CNT_W-1:0] cnt_r, cnt_nxt;
   logic expire_r, expire_nxt;

   // ------------------------------------------------------------
   // down counter on base ticks
   // ------------------------------------------------------------
   always_comb
   begin
      cnt_nxt = cnt_r;
      expire_nxt = 1'b0;
      if (load)
         cnt_nxt = load_val;
      else if (tick && cnt_r != '0)
      begin
         cnt_nxt = cnt_r - 1'b1;
         expire_nxt = (cnt_r == {{(BST_CNT_W-1){1'b0}}, 1'b1});
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cnt_r <= '0;
         expire_r <= 1'b0;
      end
      else if (ce)
      begin
         cnt_r <= cnt_nxt;
         expire_r <= expire_nxt;
      end
   end

   assign busy = (cnt_r != '0);
   assign expire = expire_r;
endmodule
`default_nettype wire

// >>> verilog/bst_start_timing.sv
`default_nettype none
module bst_start_timing
   import bst_pkg::*;
#(
   parameter int BASE_CYC = BST_BASE_CYC
)
(
   // clock, reset, enable
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [BST_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // sequencing
   input wire logic tcon_reset_rel,
   output logic conv_start,
   output logic ramp_done,
   output logic conv_running
);
   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   logic [3:0] ss_r, ss_nxt;
   logic [3:0] dly_r, dly_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic ready_r, ready_nxt;
   logic err_r, err_nxt;
   logic [31:0] pre_r, pre_nxt;
   logic rel_d_r, rel_d_nxt;
   logic start_r, start_nxt;
   logic done_r, done_nxt;
   bst_state_t st_r, st_nxt;
   logic tick;
   logic hit_ss, hit_dly, hit_st, mapped;
   logic wr_acc;
   logic rise;
   logic dly_load, ramp_load;
   logic [BST_CNT_W-1:0] dly_ticks, ramp_ticks;
   logic dly_exp, ramp_exp;

   // ------------------------------------------------------------
   // apb decode
   // ------------------------------------------------------------
   assign hit_ss = (paddr == {2'b00, BST_IDX_SOFTSTART, 2'b00});
   assign hit_dly = (paddr == {2'b00, BST_IDX_DELAY, 2'b00});
   assign hit_st = (paddr == {2'b00, BST_IDX_STATUS, 2'b00});
   assign mapped = hit_ss | hit_dly | hit_st;
   assign wr_acc = psel & penable & pwrite & ready_r & ce;

   always_comb
   begin
      ready_nxt = psel & penable & ~ready_r;
      err_nxt = psel & penable & ~ready_r & (~mapped | (pwrite & hit_st));
      rdata_nxt = rdata_r;
      ss_nxt = ss_r;
      dly_nxt = dly_r;
      if (psel & penable & ~ready_r & ~pwrite)
      begin
         rdata_nxt = 32'h0000_0000;
         if (hit_ss)
            rdata_nxt[BST_FIELD_MSB:BST_FIELD_LSB] = ss_r;
         else if (hit_dly)
            rdata_nxt[BST_FIELD_MSB:BST_FIELD_LSB] = dly_r;
         else if (hit_st)
            rdata_nxt[2:0] = {conv_running, st_r};
      end
      if (wr_acc & hit_ss)
         ss_nxt = pwdata[BST_FIELD_MSB:BST_FIELD_LSB];
      if (wr_acc & hit_dly)
         dly_nxt = pwdata[BST_FIELD_MSB:BST_FIELD_LSB];
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ss_r <= BST_SOFTSTART_RST;
         dly_r <= BST_DELAY_RST;
         rdata_r <= 32'h0000_0000;
         ready_r <= 1'b0;
         err_r <= 1'b0;
      end
      else if (ce)
      begin
         ss_r <= ss_nxt;
         dly_r <= dly_nxt;
         rdata_r <= rdata_nxt;
         ready_r <= ready_nxt;
         err_r <= err_nxt;
      end
   end

   assign pready = ready_r & ce;
   assign pslverr = err_r & ready_r & ce;
   assign prdata = rdata_r;

   // ------------------------------------------------------------
   // time base and sequencer
   // ------------------------------------------------------------
   assign tick = (pre_r == 32'(BASE_CYC - 1));
   assign rise = tcon_reset_rel & ~rel_d_r;
   assign dly_ticks = 10'(dly_r) * BST_STEP_TICKS;
   assign ramp_ticks = (ss_r == 4'h0) ? BST_MIN_RAMP_TICKS
                     : 10'(ss_r) * BST_STEP_TICKS;

   always_comb
   begin
      st_nxt = st_r;
      dly_load = 1'b0;
      ramp_load = 1'b0;
      start_nxt = 1'b0;
      done_nxt = 1'b0;
      rel_d_nxt = tcon_reset_rel;
      pre_nxt = tick ? 32'h0000_0000 : pre_r + 32'h0000_0001;
      case (st_r)
         BST_IDLE:
         begin
            if (rise)
            begin
               pre_nxt = 32'h0000_0000;
               if (dly_r == 4'h0)
               begin
                  st_nxt = BST_RAMP;
                  start_nxt = 1'b1;
                  ramp_load = 1'b1;
               end
               else
               begin
                  st_nxt = BST_DELAY;
                  dly_load = 1'b1;
               end
            end
         end
         BST_DELAY:
         begin
            if (dly_exp)
            begin
               st_nxt = BST_RAMP;
               start_nxt = 1'b1;
               ramp_load = 1'b1;
               pre_nxt = 32'h0000_0000;
            end
         end
         BST_RAMP:
         begin
            if (ramp_exp)
            begin
               st_nxt = BST_DONE;
               done_nxt = 1'b1;
            end
         end
         BST_DONE:
            st_nxt = BST_DONE;
         default:
            st_nxt = BST_IDLE;
      endcase
      if (!tcon_reset_rel)
      begin
         st_nxt = BST_IDLE;
         dly_load = 1'b1;
         ramp_load = 1'b1;
         start_nxt = 1'b0;
         done_nxt = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_r <= BST_IDLE;
         pre_r <= 32'h0000_0000;
         rel_d_r <= 1'b0;
         start_r <= 1'b0;
         done_r <= 1'b0;
      end
      else if (ce)
      begin
         st_r <= st_nxt;
         pre_r <= pre_nxt;
         rel_d_r <= rel_d_nxt;
         start_r <= start_nxt;
         done_r <= done_nxt;
      end
   end

   bst_interval_timer u_delay
   (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .load(dly_load),
      .load_val(tcon_reset_rel ? dly_ticks : 10'h000),
      .tick(tick),
      .busy(),
      .expire(dly_exp)
   );

   bst_interval_timer u_ramp
   (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .load(ramp_load),
      .load_val(tcon_reset_rel ? ramp_ticks : 10'h000),
      .tick(tick),
      .busy(),
      .expire(ramp_exp)
   );

   assign conv_start = start_r;
   assign ramp_done = done_r;
   assign conv_running = (st_r == BST_RAMP) | (st_r == BST_DONE);
endmodule
`default_nettype wire

// >>> tb/bst_start_timing_chk.sv
`default_nettype none
module bst_start_timing_chk
   import bst_pkg::*;
#(
   parameter int BASE_CYC = BST_BASE_CYC
)
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb
   input wire logic pwrite,
   input wire logic [31:0] prdata,
   input wire logic pready,
   // sequencing
   input wire logic tcon_reset_rel,
   input wire logic conv_start,
   input wire logic ramp_done,
   input wire logic conv_running
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------
   // ramp cycle count
   // ----------------
   logic [31:0] cnt_r;
   logic [31:0] cnt_nxt;
   always_comb cnt_nxt = conv_start ? 32'h0000_0000 : cnt_r + 32'h0000_0001;
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         cnt_r <= 32'h0000_0000;
      else
         cnt_r <= cnt_nxt;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_quiet;
      (!ramp_done) [*8];
   endsequence
   property p_rd_upper;
      pready && !pwrite |-> prdata[31:4] == 28'h0;
   endproperty
   property p_one_ready;
      pready |=> !pready;
   endproperty
   property p_start_run;
      conv_start |-> ##[0:2] conv_running;
   endproperty
   property p_start_quiet;
      conv_start |=> s_quiet;
   endproperty
   property p_abort;
      (!tcon_reset_rel) [*2] |-> !conv_start && !ramp_done && !conv_running;
   endproperty
   property p_ramp_min;
      ramp_done |-> cnt_r >= 32'(BASE_CYC - 2);
   endproperty
   a_rd_upper: assert property (p_rd_upper) else $error("upper read bits set");
   a_one_ready: assert property (p_one_ready) else $error("pready too long");
   a_start_run: assert property (p_start_run) else $error("no running");
   a_start_quiet: assert property (p_start_quiet) else $error("ramp early");
   a_abort: assert property (p_abort) else $error("output after abort");
   a_ramp_min: assert property (p_ramp_min) else $error("ramp too short");
endmodule
bind bst_start_timing bst_start_timing_chk #(.BASE_CYC(BASE_CYC)) i_bst_start_timing_chk (
   .pclk, .presetn, .pwrite, .prdata, .pready,
   .tcon_reset_rel, .conv_start, .ramp_done, .conv_running);
`default_nettype wire

// >>> tb/test_bst_start_timing.sv
`default_nettype none
module test_bst_start_timing
   import bst_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int B = 10;
   localparam logic [11:0] A_SS = {2'b00, BST_IDX_SOFTSTART, 2'b00};
   localparam logic [11:0] A_DL = {2'b00, BST_IDX_DELAY, 2'b00};
   localparam logic [11:0] A_ST = {2'b00, BST_IDX_STATUS, 2'b00};
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, tcon_reset_rel = 0;
   logic ce = 1;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd;
   logic pready, pslverr, conv_start, ramp_done, conv_running, er;
   int n_fail = 0, num_checks = 0, k;
   always #2.5 pclk = ~pclk;
   bst_start_timing #(.BASE_CYC(B)) i_bst_start_timing (
      .pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .tcon_reset_rel, .conv_start, .ramp_done,
      .conv_running);
   // ----------------
   // tasks
   // ----------------
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
      num_checks++;
      if (s !== x)
      begin
         $display("wrong value %s exp %h seen %h", n, x, s);
         n_fail++;
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int j;
      @(posedge pclk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      j = 0;
      do @(posedge pclk); while (pready !== 1'b1 && ++j < 50);
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
      if (j >= 50)
         n_fail++;
   endtask
   task automatic run_seq(input logic [3:0] d, input logic [3:0] s);
      int e;
      apb(1, A_DL, {28'h0, d});
      apb(1, A_SS, {28'h0, s});
      @(posedge pclk);
      tcon_reset_rel <= 1;
      k = 1;
      do @(negedge pclk); while (conv_start !== 1'b1 && ++k < 2000);
      e = d * 10 * B;
      chk("start", {31'h0, k >= e && k <= e + 4}, 1);
      k = 1;
      do @(negedge pclk); while (ramp_done !== 1'b1 && ++k < 2000);
      e = (s == 0) ? B : s * 10 * B;
      chk("ramp", {31'h0, k >= e - 1 && k <= e + 4}, 1);
      @(posedge pclk);
      tcon_reset_rel <= 0;
      repeat (3) @(posedge pclk);
   endtask
   task automatic tally_and_finish;
      $display("checks %0d fails %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // ----------------
   // tests
   // ----------------
   initial
   begin
      #100us;
      n_fail++;
      tally_and_finish();
   end
   initial
   begin
      repeat (5) @(posedge pclk);
      presetn <= 1;
      apb(0, A_SS, 0);
      chk("ss reset", rd, 32'h4);
      chk("ss err", {31'h0, er}, 0);
      apb(0, A_DL, 0);
      chk("dly reset", rd, 32'h2);
      apb(1, A_DL, 32'hffff_ffa5);
      apb(0, A_DL, 0);
      chk("dly readback", rd, 32'h5);
      apb(1, A_SS, 32'h5a5a_5af0);
      apb(0, A_SS, 0);
      chk("ss readback", rd, 32'h0);
      apb(0, 12'h040, 0);
      chk("unmapped err", {31'h0, er}, 1);
      apb(1, A_ST, 1);
      chk("status err", {31'h0, er}, 1);
      run_seq(4'h0, 4'h0);
      run_seq(4'h1, 4'hf);
      run_seq(4'hf, 4'h1);
      apb(1, A_DL, 2);
      @(posedge pclk);
      tcon_reset_rel <= 1;
      repeat (90) @(posedge pclk);
      apb(0, A_ST, 0);
      chk("status delay", rd, 32'h1);
      tcon_reset_rel <= 0;
      k = 0;
      repeat (300) @(negedge pclk) k += int'(conv_start | conv_running);
      chk("abort", k, 0);
      @(posedge pclk);
      ce <= 1'b0;
      tcon_reset_rel <= 1;
      repeat (50) @(posedge pclk);
      ce <= 1'b1;
      k = 1;
      do @(negedge pclk); while (conv_start !== 1'b1 && ++k < 2000);
      chk("ce freeze", {31'h0, k >= 20 * B && k <= 20 * B + 4}, 1);
      tally_and_finish();
   end
endmodule
`default_nettype wire
